/* dtc_timer_pair.sv */
`timescale 1ns/100ps
`include "dtc_defines.svh"
module dtc_timer_pair (
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    // Special function register port
    input  wire dtc_pkg::dtc_sfr_req_s SFR_REQ,
    output logic [7:0]                SFR_RDATA,
    // External pins
    input  wire logic                 TIMER_ZERO_EVENT_PIN,
    input  wire logic                 TIMER_ONE_EVENT_PIN,
    input  wire logic                 EXTERNAL_REQUEST_ZERO_INPUT,
    input  wire logic                 EXTERNAL_REQUEST_ONE_INPUT,
    input  wire logic                 EXT_OSC_CLK,
    // Bits held by the interrupt block
    input  wire logic                 REQUEST_ZERO_POLARITY,
    input  wire logic                 REQUEST_ONE_POLARITY,
    input  wire logic                 TIMER_ZERO_IRQ_ENABLE,
    input  wire logic                 TIMER_ONE_IRQ_ENABLE,
    input  wire logic                 TIMER_ZERO_VECTOR_ACK,
    input  wire logic                 TIMER_ONE_VECTOR_ACK,
    // Requests, ticks and clock picks
    output logic                      TIMER_ZERO_IRQ,
    output logic                      TIMER_ONE_IRQ,
    output logic                      TIMER_ONE_OVF_TICK,
    output logic [3:0]                TIMER_TWO_THREE_CLOCK_PICKS
);

    logic [7:0] clksel_q, ctrl_q, mode_q, t0_lo_q, t0_hi_q, t1_lo_q, t1_hi_q;
    logic [1:0] t0_ev_s, t1_ev_s, rq0_s, rq1_s, osc_s;
    logic       t0_ev_prev_q, t1_ev_prev_q, osc_prev_q;
    logic [5:0] pre_cnt_q;
    logic [2:0] ext_div_q;
    logic       t0_fall, t1_fall, osc_rise, presc_tick;
    logic       wr_ctrl, wr_mode, wr_t0l, wr_t0h, wr_t1l, wr_t1h;
    logic       t0_split, t0_run, t0h_run, t1_run;
    logic       t0_tick, t0h_tick, t1_tick;
    logic       ovf0_set, ovf1_set, t1_ovf;
    logic [5:0] pre_last;
    dtc_pkg::dtc_mode_e mode0, mode1;
    dtc_pkg::dtc_step_s st0, st1;
    logic [8:0] t0h_sum;

    // Address decode shared by all write paths
    function automatic logic hit(input dtc_pkg::dtc_sfr_req_s r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    // One count step of a timer byte pair in the given mode
    function automatic dtc_pkg::dtc_step_s timer_step(input dtc_pkg::dtc_mode_e m,
                                                     input logic [7:0] lo, input logic [7:0] hi);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0]  s8;
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8  = {1'b0, lo} + 9'h001;
        timer_step = '{lo: lo, hi: hi, ovf: 1'b0};
        unique case (m)
            dtc_pkg::DTC_MODE_13BIT: begin
                // Upper three low-byte bits are left untouched by counting
                timer_step = '{lo: {lo[7:5], s13[4:0]}, hi: s13[12:5], ovf: s13[13]};
            end
            dtc_pkg::DTC_MODE_16BIT: begin
                timer_step = '{lo: s16[7:0], hi: s16[15:8], ovf: s16[16]};
            end
            dtc_pkg::DTC_MODE_8RELOAD: begin
                timer_step = '{lo: s8[8] ? hi : s8[7:0], hi: hi, ovf: s8[8]};
            end
            dtc_pkg::DTC_MODE_SPLIT: begin
                timer_step = '{lo: s8[7:0], hi: hi, ovf: s8[8]};
            end
        endcase
    endfunction

    assign wr_ctrl = hit(SFR_REQ, `DTC_ADDR_CTRL);
    assign wr_mode = hit(SFR_REQ, `DTC_ADDR_MODE);
    assign wr_t0l  = hit(SFR_REQ, `DTC_ADDR_T0_LO);
    assign wr_t0h  = hit(SFR_REQ, `DTC_ADDR_T0_HI);
    assign wr_t1l  = hit(SFR_REQ, `DTC_ADDR_T1_LO);
    assign wr_t1h  = hit(SFR_REQ, `DTC_ADDR_T1_HI);

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            t0_ev_s <= 2'h3;
            t1_ev_s <= 2'h3;
            rq0_s   <= 2'h0;
            rq1_s   <= 2'h0;
            osc_s   <= 2'h0;
            t0_ev_prev_q <= 1'b1;
            t1_ev_prev_q <= 1'b1;
            osc_prev_q   <= 1'b0;
        end else begin
            t0_ev_s <= {t0_ev_s[0], TIMER_ZERO_EVENT_PIN};
            t1_ev_s <= {t1_ev_s[0], TIMER_ONE_EVENT_PIN};
            rq0_s   <= {rq0_s[0], EXTERNAL_REQUEST_ZERO_INPUT};
            rq1_s   <= {rq1_s[0], EXTERNAL_REQUEST_ONE_INPUT};
            osc_s   <= {osc_s[0], EXT_OSC_CLK};
            t0_ev_prev_q <= t0_ev_s[1];
            t1_ev_prev_q <= t1_ev_s[1];
            osc_prev_q   <= osc_s[1];
        end
    end

    // Edges come from registered samples, so one transition gives one count
    assign t0_fall  = t0_ev_prev_q && !t0_ev_s[1];
    assign t1_fall  = t1_ev_prev_q && !t1_ev_s[1];
    assign osc_rise = !osc_prev_q && osc_s[1];

    // Prescaler
    always_comb begin
        unique case (clksel_q[1:0])
            2'h0:    pre_last = `DTC_DIV12_LAST;
            2'h1:    pre_last = `DTC_DIV4_LAST;
            default: pre_last = `DTC_DIV48_LAST;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pre_cnt_q <= 6'h00;
            ext_div_q <= 3'h0;
        end else begin
            // A code change may stretch one period; counting restarts cleanly after it
            pre_cnt_q <= (pre_cnt_q >= pre_last) ? 6'h00 : pre_cnt_q + 6'h01;
            if (osc_rise) begin
                ext_div_q <= ext_div_q + 3'h1;
            end
        end
    end

    assign presc_tick = (clksel_q[1:0] == 2'h3) ? (osc_rise && ext_div_q == `DTC_EXT_DIV_LAST)
                                                 : (pre_cnt_q == pre_last);

    // Run and tick decode
    assign mode0    = dtc_pkg::dtc_mode_e'(mode_q[1:0]);
    assign mode1    = dtc_pkg::dtc_mode_e'(mode_q[5:4]);
    assign t0_split = (mode0 == dtc_pkg::DTC_MODE_SPLIT);
    assign t0_run   = ctrl_q[`DTC_CTRL_TR0_BIT] &&
                      (!mode_q[`DTC_MODE_TIMER_ZERO_EXTERNAL_GATING] || (rq0_s[1] == REQUEST_ZERO_POLARITY));
    assign t0h_run  = ctrl_q[`DTC_CTRL_TR1_BIT];
    assign t1_run   = t0_split ? (mode1 != dtc_pkg::DTC_MODE_SPLIT)
                               : (ctrl_q[`DTC_CTRL_TR1_BIT] && (mode1 != dtc_pkg::DTC_MODE_SPLIT) &&
                                  (!mode_q[`DTC_MODE_TIMER_ONE_EXTERNAL_GATING] || (rq1_s[1] == REQUEST_ONE_POLARITY)));
    assign t0_tick  = t0_run && (mode_q[`DTC_MODE_EVT0] ? t0_fall
                               : (clksel_q[`DTC_CLK_T0_BIT] || presc_tick));
    assign t0h_tick = t0_split && t0h_run && (clksel_q[`DTC_CLK_T0_BIT] || presc_tick);
    assign t1_tick  = t1_run && ((mode_q[`DTC_MODE_EVT1] && !t0_split) ? t1_fall
                               : (clksel_q[`DTC_CLK_T1_BIT] || presc_tick));

    assign st0      = timer_step(mode0, t0_lo_q, t0_hi_q);
    assign st1      = timer_step(mode1, t1_lo_q, t1_hi_q);
    assign t0h_sum  = {1'b0, t0_hi_q} + 9'h001;
    assign ovf0_set = t0_tick && st0.ovf;
    assign t1_ovf   = t1_tick && st1.ovf;
    assign ovf1_set = t0_split ? (t0h_tick && t0h_sum[8]) : t1_ovf;

    // Configuration registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            clksel_q <= `DTC_RESET_BYTE;
            mode_q   <= `DTC_RESET_BYTE;
        end else begin
            if (hit(SFR_REQ, `DTC_ADDR_CLKSEL)) begin
                clksel_q <= SFR_REQ.wdata;
            end
            if (wr_mode) begin
                mode_q <= SFR_REQ.wdata;
            end
        end
    end

    // Control register; a hardware set beats a software or vector clear
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_q <= `DTC_RESET_BYTE;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= SFR_REQ.wdata;
            end
            if (TIMER_ZERO_VECTOR_ACK && !(wr_ctrl && SFR_REQ.wdata[`DTC_CTRL_TF0_BIT])) begin
                ctrl_q[`DTC_CTRL_TF0_BIT] <= 1'b0;
            end
            if (TIMER_ONE_VECTOR_ACK && !(wr_ctrl && SFR_REQ.wdata[`DTC_CTRL_TF1_BIT])) begin
                ctrl_q[`DTC_CTRL_TF1_BIT] <= 1'b0;
            end
            if (ovf0_set) begin
                ctrl_q[`DTC_CTRL_TF0_BIT] <= 1'b1;
            end
            if (ovf1_set) begin
                ctrl_q[`DTC_CTRL_TF1_BIT] <= 1'b1;
            end
        end
    end

    // Timer zero bytes; software writes take priority over counting
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            t0_lo_q <= `DTC_RESET_BYTE;
            t0_hi_q <= `DTC_RESET_BYTE;
        end else begin
            if (wr_t0l) begin
                t0_lo_q <= SFR_REQ.wdata;
            end else if (t0_tick) begin
                t0_lo_q <= st0.lo;
            end
            if (wr_t0h) begin
                t0_hi_q <= SFR_REQ.wdata;
            end else if (t0h_tick) begin
                t0_hi_q <= t0h_sum[7:0];
            end else if (t0_tick && !t0_split) begin
                t0_hi_q <= st0.hi;
            end
        end
    end

    // Timer one bytes
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            t1_lo_q <= `DTC_RESET_BYTE;
            t1_hi_q <= `DTC_RESET_BYTE;
        end else begin
            if (wr_t1l) begin
                t1_lo_q <= SFR_REQ.wdata;
            end else if (t1_tick) begin
                t1_lo_q <= st1.lo;
            end
            if (wr_t1h) begin
                t1_hi_q <= SFR_REQ.wdata;
            end else if (t1_tick) begin
                t1_hi_q <= st1.hi;
            end
        end
    end

    // Outputs and read data
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            SFR_RDATA                   <= 8'h00;
            TIMER_ZERO_IRQ              <= 1'b0;
            TIMER_ONE_IRQ               <= 1'b0;
            TIMER_ONE_OVF_TICK          <= 1'b0;
            TIMER_TWO_THREE_CLOCK_PICKS <= 4'h0;
        end else begin
            TIMER_ZERO_IRQ     <= ctrl_q[`DTC_CTRL_TF0_BIT] && TIMER_ZERO_IRQ_ENABLE;
            TIMER_ONE_IRQ      <= ctrl_q[`DTC_CTRL_TF1_BIT] && TIMER_ONE_IRQ_ENABLE;
            TIMER_ONE_OVF_TICK <= t1_ovf;
            TIMER_TWO_THREE_CLOCK_PICKS <= clksel_q[7:4];
            if (SFR_REQ.rd) begin
                unique case (SFR_REQ.addr)
                    `DTC_ADDR_CTRL:   SFR_RDATA <= ctrl_q;
                    `DTC_ADDR_MODE:   SFR_RDATA <= mode_q;
                    `DTC_ADDR_T0_LO:  SFR_RDATA <= t0_lo_q;
                    `DTC_ADDR_T1_LO:  SFR_RDATA <= t1_lo_q;
                    `DTC_ADDR_T0_HI:  SFR_RDATA <= t0_hi_q;
                    `DTC_ADDR_T1_HI:  SFR_RDATA <= t1_hi_q;
                    `DTC_ADDR_CLKSEL: SFR_RDATA <= clksel_q;
                    default:          SFR_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // Checks
    sequence s_t0_pin_fall;
        t0_ev_s[1] ##1 !t0_ev_s[1];
    endsequence

    sequence s_t0_free_count;
        mode0 == dtc_pkg::DTC_MODE_16BIT && mode_q[`DTC_MODE_EVT0] && t0_run && !wr_t0l && !wr_t0h && !wr_mode;
    endsequence

    a_event_counts_once: assert property (@(posedge CLK) disable iff (!RST_N)
        (s_t0_pin_fall ##0 s_t0_free_count) |=> ({t0_hi_q, t0_lo_q} == $past({t0_hi_q, t0_lo_q}) + 16'h0001))
        else $error("event edge did not count once");

    a_overflow_sets_flag: assert property (@(posedge CLK) disable iff (!RST_N)
        ovf0_set |=> ctrl_q[`DTC_CTRL_TF0_BIT])
        else $error("overflow did not set flag zero");

    a_irq_needs_enable: assert property (@(posedge CLK) disable iff (!RST_N)
        TIMER_ZERO_IRQ |-> $past(ctrl_q[`DTC_CTRL_TF0_BIT] && TIMER_ZERO_IRQ_ENABLE))
        else $error("timer zero request without enabled flag");

    a_reload_from_high: assert property (@(posedge CLK) disable iff (!RST_N)
        (ovf0_set && mode0 == dtc_pkg::DTC_MODE_8RELOAD && !wr_t0l && !wr_t0h)
            |=> (t0_lo_q == $past(t0_hi_q)) && $stable(t0_hi_q))
        else $error("mode 2 reload wrong");

    a_stop_holds_count: assert property (@(posedge CLK) disable iff (!RST_N)
        (!ctrl_q[`DTC_CTRL_TR0_BIT] && !t0_split && !wr_t0l && !wr_t0h) |=> $stable({t0_hi_q, t0_lo_q}))
        else $error("stopped timer zero moved");

    a_div12_spacing: assert property (@(posedge CLK) disable iff (!RST_N)
        (presc_tick && clksel_q[1:0] == 2'h0 && !hit(SFR_REQ, `DTC_ADDR_CLKSEL))
            |=> (!presc_tick || clksel_q[1:0] != 2'h0) [*8] ##1
                (!presc_tick || clksel_q[1:0] != 2'h0) ##1 (!presc_tick || clksel_q[1:0] != 2'h0))
        else $error("divide by twelve tick too early");

    a_split_t1_silent: assert property (@(posedge CLK) disable iff (!RST_N)
        (t0_split && t1_ovf && !(t0h_tick && t0h_sum[8]) && !ctrl_q[`DTC_CTRL_TF1_BIT] && !wr_ctrl)
            |=> !ctrl_q[`DTC_CTRL_TF1_BIT] && TIMER_ONE_OVF_TICK)
        else $error("timer one flagged while split");

    a_split_t1_stops: assert property (@(posedge CLK) disable iff (!RST_N)
        (t0_split && mode1 == dtc_pkg::DTC_MODE_SPLIT && !wr_t1l && !wr_t1h) |=> $stable({t1_hi_q, t1_lo_q}))
        else $error("timer one ran in mode 3 while split");

    a_set_beats_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        (ovf1_set && TIMER_ONE_VECTOR_ACK) |=> ctrl_q[`DTC_CTRL_TF1_BIT])
        else $error("flag one lost to clear");

    a_event_pick_ignored: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode_q[`DTC_MODE_EVT0] && !t0_fall) |-> !t0_tick)
        else $error("timer zero ticked without event edge");
endmodule

/* dtc_defines.svh */
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH
// Summary of operation
// - Divider code 00 gives clock/12, 01 gives clock/4, 10 gives clock/48.
// - Divider code 11 gives external oscillator divided by eight, synchronised first.
// - Timer one clock pick bit 3: 0 prescaled, 1 system; ignored when counting events.
// - Timer zero clock pick bit 2: 0 prescaled, 1 system; ignored when counting events.
// - Bits 7..4 are per-byte clock picks for timers three and two.
// - Each timer is a 16-bit count read and written as two bytes.
// - Mode 0 count is 13 bits: high byte plus low byte bits 4..0.
// - 13-bit wrap to zero sets the overflow flag and may request an interrupt.
// - Event select 1 counts falling pin edges; 0 counts the picked clock.
// - Timer counts when run bit set and gating off or request input active.
// - Timer one mirrors timer zero in modes 0-2 with its own bytes, bits and request input; mode 3 stops it.
// - Mode 1 is mode 0 using all sixteen bits.
// - Mode 2 low byte counts, reloads from high byte on wrap, sets flag.
// - Timer zero mode 3 low byte uses timer zero controls, clock or events.
// - Mode 3 high byte is a clock-only timer on timer one run and flag.
// - With timer zero in mode 3, timer one counts no events, sets no flag.
// - With timer zero in mode 3, timer one runs in modes 0-2, stops in 3.
// - Each timer takes its mode from its own two-bit field, independently.
// - An overflow flag requests an interrupt only when its enable bit is set.
// - Hardware sets overflow flags; software or the interrupt vector clears them.
// - Mode field 00 is mode 0; codes 01..11 are modes 1..3.

// Register addresses
`define DTC_ADDR_CTRL     8'h88
`define DTC_ADDR_MODE     8'h89
`define DTC_ADDR_T0_LO    8'h8A
`define DTC_ADDR_T1_LO    8'h8B
`define DTC_ADDR_T0_HI    8'h8C
`define DTC_ADDR_T1_HI    8'h8D
`define DTC_ADDR_CLKSEL   8'h8E
`define DTC_RESET_BYTE    8'h00
// Field positions
`define DTC_CLK_T1_BIT    3
`define DTC_CLK_T0_BIT    2
`define DTC_CTRL_TF1_BIT  7
`define DTC_CTRL_TR1_BIT  6
`define DTC_CTRL_TF0_BIT  5
`define DTC_CTRL_TR0_BIT  4
`define DTC_MODE_TIMER_ONE_EXTERNAL_GATING    7
`define DTC_MODE_EVT1     6
`define DTC_MODE_TIMER_ZERO_EXTERNAL_GATING    3
`define DTC_MODE_EVT0     2
// Prescaler terminal counts (divide minus one)
`define DTC_DIV12_LAST    6'h0B
`define DTC_DIV4_LAST     6'h03
`define DTC_DIV48_LAST    6'h2F
`define DTC_EXT_DIV_LAST  3'h7
`endif

/* dtc_pkg.sv */
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_MODE_13BIT,
        DTC_MODE_16BIT,
        DTC_MODE_8RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_e;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic       ovf;
    } dtc_step_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dtc_sfr_req_s;
endpackage

/* dtc_pin_model.sv */
`timescale 1ns/100ps
module dtc_pin_model (
    // Clock
    input  wire logic clk,
    // Pins toward the timers
    output logic      ev_zero,
    output logic      ev_one,
    output logic      gate_zero,
    output logic      gate_one,
    output logic      osc
);
    // Oscillator runs free, phase unrelated to the system clock
    initial begin
        ev_zero = 1'b1;
        ev_one = 1'b1;
        gate_zero = 1'b0;
        gate_one = 1'b0;
        osc = 1'b0;
        #1.3;
        forever #20 osc = ~osc;
    end

    // Each level held three clocks, above the two-clock minimum
    task automatic falls(input int unsigned pin, input int unsigned n);
        repeat (n) begin
            @(posedge clk);
            if (pin == 0) ev_zero <= 1'b0;
            else ev_one <= 1'b0;
            repeat (3) @(posedge clk);
            if (pin == 0) ev_zero <= 1'b1;
            else ev_one <= 1'b1;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask

    task automatic set_gate(input logic lvl);
        @(posedge clk);
        gate_zero <= lvl;
        repeat (4) @(posedge clk);
    endtask
endmodule

/* tb_dual_timer_counter_with_prescaler.sv */
`timescale 1ns/100ps
`include "dtc_defines.svh"
module tb_dual_timer_counter_with_prescaler;
    logic                  clk;
    logic                  rst_n;
    dtc_pkg::dtc_sfr_req_s req;
    logic [7:0]            rdata;
    logic                  ev0, ev1, g0, g1, osc;
    logic                  pol0, pol1, en0, en1, ack0, ack1;
    logic                  irq0, irq1, tick;
    logic [3:0]            picks;
    logic [7:0]            d;
    int                    num_errors;
    int                    tests_run;

    dtc_timer_pair DUT (.CLK(clk), .RST_N(rst_n), .SFR_REQ(req), .SFR_RDATA(rdata),
        .TIMER_ZERO_EVENT_PIN(ev0), .TIMER_ONE_EVENT_PIN(ev1), .EXTERNAL_REQUEST_ZERO_INPUT(g0),
        .EXTERNAL_REQUEST_ONE_INPUT(g1), .EXT_OSC_CLK(osc), .REQUEST_ZERO_POLARITY(pol0),
        .REQUEST_ONE_POLARITY(pol1), .TIMER_ZERO_IRQ_ENABLE(en0), .TIMER_ONE_IRQ_ENABLE(en1),
        .TIMER_ZERO_VECTOR_ACK(ack0), .TIMER_ONE_VECTOR_ACK(ack1), .TIMER_ZERO_IRQ(irq0),
        .TIMER_ONE_IRQ(irq1), .TIMER_ONE_OVF_TICK(tick), .TIMER_TWO_THREE_CLOCK_PICKS(picks));
    dtc_pin_model pm (.clk(clk), .ev_zero(ev0), .ev_one(ev1), .gate_zero(g0), .gate_one(g1), .osc(osc));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, v};
        @(posedge clk);
        req <= '0;
    endtask

    // Data is registered at the read edge, so it is taken just after that edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        d = rdata;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(what, exp, d);
    endtask

    task automatic t_regs;
        for (int a = 8'h88; a <= 8'h8E; a++) rchk("reset value", a[7:0], 8'h00);
        rchk("unmapped", 8'h90, 8'h00);
        wr(`DTC_ADDR_CLKSEL, 8'hF5);
        rchk("clock select", `DTC_ADDR_CLKSEL, 8'hF5);
        chk("byte picks", 8'h0F, {4'h0, picks});
        wr(`DTC_ADDR_CLKSEL, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_mode0;
        wr(`DTC_ADDR_MODE, 8'h04);
        wr(`DTC_ADDR_T0_HI, 8'hFF);
        wr(`DTC_ADDR_T0_LO, 8'h1F);
        wr(`DTC_ADDR_CTRL, 8'h10);
        pm.falls(0, 3);
        rchk("t0 flag", `DTC_ADDR_CTRL, 8'h30);
        rchk("t0 high", `DTC_ADDR_T0_HI, 8'h00);
        rd(`DTC_ADDR_T0_LO);
        chk("t0 low five", 8'h02, d & 8'h1F);
        chk("irq masked", 8'h00, {7'h00, irq0});
        en0 <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq raised", 8'h01, {7'h00, irq0});
        ack0 <= 1'b1;
        @(posedge clk);
        ack0 <= 1'b0;
        repeat (3) @(posedge clk);
        chk("irq acked", 8'h00, {7'h00, irq0});
        rchk("flag acked", `DTC_ADDR_CTRL, 8'h10);
        wr(`DTC_ADDR_CTRL, 8'h00);
        en0 <= 1'b0;
        $display("test mode0 done");
    endtask

    task automatic t_mode1;
        wr(`DTC_ADDR_CLKSEL, 8'h08);
        wr(`DTC_ADDR_MODE, 8'h50);
        wr(`DTC_ADDR_T1_HI, 8'hFF);
        wr(`DTC_ADDR_T1_LO, 8'hFE);
        en1 <= 1'b1;
        wr(`DTC_ADDR_CTRL, 8'h40);
        pm.falls(1, 3);
        rchk("t1 high", `DTC_ADDR_T1_HI, 8'h00);
        rchk("t1 low", `DTC_ADDR_T1_LO, 8'h01);
        rchk("t1 flag", `DTC_ADDR_CTRL, 8'hC0);
        chk("irq1 raised", 8'h01, {7'h00, irq1});
        wr(`DTC_ADDR_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        chk("irq1 cleared", 8'h00, {7'h00, irq1});
        en1 <= 1'b0;
        wr(`DTC_ADDR_CLKSEL, 8'h00);
        $display("test mode1 done");
    endtask

    task automatic t_reload;
        wr(`DTC_ADDR_MODE, 8'h06);
        wr(`DTC_ADDR_T0_HI, 8'hF0);
        wr(`DTC_ADDR_T0_LO, 8'hFE);
        wr(`DTC_ADDR_CTRL, 8'h10);
        pm.falls(0, 4);
        rchk("reload low", `DTC_ADDR_T0_LO, 8'hF2);
        rchk("reload high", `DTC_ADDR_T0_HI, 8'hF0);
        rchk("reload flag", `DTC_ADDR_CTRL, 8'h30);
        wr(`DTC_ADDR_CTRL, 8'h00);
        $display("test reload done");
    endtask

    task automatic t_gate;
        wr(`DTC_ADDR_MODE, 8'h0D);
        wr(`DTC_ADDR_T0_LO, 8'h00);
        wr(`DTC_ADDR_CTRL, 8'h10);
        pm.falls(0, 2);
        rchk("gate closed", `DTC_ADDR_T0_LO, 8'h00);
        pm.set_gate(1'b1);
        pm.falls(0, 2);
        rchk("gate open", `DTC_ADDR_T0_LO, 8'h02);
        pol0 <= 1'b0;
        pm.falls(0, 2);
        rchk("polarity low", `DTC_ADDR_T0_LO, 8'h02);
        pol0 <= 1'b1;
        wr(`DTC_ADDR_CTRL, 8'h00);
        pm.falls(0, 2);
        wr(`DTC_ADDR_CTRL, 8'h10);
        rchk("run kept count", `DTC_ADDR_T0_LO, 8'h02);
        wr(`DTC_ADDR_CTRL, 8'h00);
        pm.set_gate(1'b0);
        $display("test gate done");
    endtask

    task automatic count_ticks(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (tick === 1'b1) c++;
        end
    endtask

    task automatic t_split;
        int c;
        wr(`DTC_ADDR_CLKSEL, 8'h04);
        wr(`DTC_ADDR_MODE, 8'h07);
        wr(`DTC_ADDR_T0_LO, 8'hFE);
        wr(`DTC_ADDR_T0_HI, 8'hFE);
        wr(`DTC_ADDR_CTRL, 8'h40);
        repeat (8) @(posedge clk);
        rchk("high byte flag", `DTC_ADDR_CTRL, 8'hC0);
        // Clear the flag, then land an ack on the very edge where the high byte wraps
        wr(`DTC_ADDR_CTRL, 8'h40);
        wr(`DTC_ADDR_T0_HI, 8'hFF);
        ack1 <= 1'b1;
        @(posedge clk);
        ack1 <= 1'b0;
        rchk("set beats ack", `DTC_ADDR_CTRL, 8'hC0);
        rchk("low byte idle", `DTC_ADDR_T0_LO, 8'hFE);
        wr(`DTC_ADDR_CTRL, 8'h10);
        pm.falls(0, 2);
        rchk("low byte wrap", `DTC_ADDR_T0_LO, 8'h00);
        rchk("low byte flag", `DTC_ADDR_CTRL, 8'h30);
        wr(`DTC_ADDR_CTRL, 8'h00);
        wr(`DTC_ADDR_CLKSEL, 8'h0C);
        wr(`DTC_ADDR_T1_HI, 8'h00);
        wr(`DTC_ADDR_MODE, 8'h27);
        count_ticks(600, c);
        chk("t1 still ticks", 8'h01, {7'h00, c >= 2});
        rchk("no t1 flag", `DTC_ADDR_CTRL, 8'h00);
        wr(`DTC_ADDR_MODE, 8'h37);
        count_ticks(300, c);
        chk("t1 stopped", 8'h00, c[7:0]);
        $display("test split done");
    endtask

    task automatic t_presc;
        logic [7:0] sel [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08};
        logic [7:0] per [5] = '{8'h0C, 8'h04, 8'h30, 8'h40, 8'h01};
        int k;
        wr(`DTC_ADDR_MODE, 8'h20);
        wr(`DTC_ADDR_T1_HI, 8'hFF);
        // Low byte is left over from earlier tests; preload it so every tick overflows
        wr(`DTC_ADDR_T1_LO, 8'hFF);
        wr(`DTC_ADDR_CTRL, 8'h40);
        for (int i = 0; i < 5; i++) begin
            wr(`DTC_ADDR_CLKSEL, sel[i]);
            // First gap may be stretched by the divider restart
            repeat (2) begin
                k = 0;
                do begin
                    @(posedge clk);
                    #1;
                    k++;
                end while (tick !== 1'b1 && k < 200);
            end
            chk("tick period", per[i], k[7:0]);
        end
        wr(`DTC_ADDR_CTRL, 8'h00);
        $display("test prescaler done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        wrap_up;
    end

    initial begin
        num_errors = 0;
        tests_run = 0;
        rst_n = 1'b0;
        req = '0;
        {pol0, pol1, en0, en1, ack0, ack1} = 6'h30;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_mode0;
        t_mode1;
        t_reload;
        t_gate;
        t_split;
        t_presc;
        wrap_up;
    end
endmodule
